// file: hdl/ssi_enc_pkg.sv
package ssi_enc_pkg;
    // position word
    localparam int POS_W = 25;
    localparam int TURN_W = 13;
    localparam int CNT_W = 5;
    localparam logic [POS_W-1:0] POS_RST = 25'h0;
    localparam logic [CNT_W-1:0] CNT_RST = 5'h0;
    localparam logic [CNT_W-1:0] LAST_BIT = 5'h19;
    // line levels
    localparam logic LINE_IDLE = 1'b1;
    localparam logic LINE_MONO = 1'b0;
    // clock and timing
    localparam int CLK_HZ = 50_000_000;
    localparam int AVAIL_MS = 450;
    localparam int AVAIL_CYC = (CLK_HZ / 1000) * AVAIL_MS;
    localparam int AVAIL_W = 25;
    localparam logic [AVAIL_W-1:0] AVAIL_RST = 25'h0;
    localparam int MONO_US = 20;
    localparam int MONO_CYC = (CLK_HZ / 1_000_000) * MONO_US;
    localparam int MONO_W = 16;
    localparam logic [MONO_W-1:0] MONO_RST = 16'h0;
    // transfer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_MONO = 3'b100
    } ssi_state_t;
endpackage : ssi_enc_pkg

// file: hdl/sync2.sv
`timescale 1ns/1ps
module sync2 #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // level in and out
    input wire logic d,
    output logic q
);
    logic meta_r;
    logic meta_nxt;
    logic q_nxt;

    always_comb begin
        meta_nxt = d;
        q_nxt = meta_r;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_r <= meta_nxt;
            q <= q_nxt;
        end
    end
endmodule : sync2

// file: hdl/ssi_encoder.sv
// Operation
// R1: position is 25 bits, low 13 steps per turn, upper bits whole turns
// R2: sent word is Gray coded or plain binary by coding variant
// R3: direction low counts up clockwise, high counts down clockwise
// R4: falling edge on zero-set makes the position read zero
// R5: no valid data for up to 450 ms after power-up
// R6: idle clock and data lines both stay high
// R7: first falling clock edge captures position into the shift register
// R8: MSB out at first rising edge, next lower bit each later rising edge
// R9: after LSB data low until monoflop time from last falling edge
// R10: coding choice and monoflop length are static block parameters
`timescale 1ns/1ps
module ssi_encoder #(
    parameter bit GRAY_OUT = 1'b1,
    parameter int MONO_CYC = ssi_enc_pkg::MONO_CYC,
    parameter int AVAIL_CYC = ssi_enc_pkg::AVAIL_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // ssi link pins
    input wire logic ssi_clk,
    output logic ssi_data,
    // configuration pins
    input wire logic dir_sel,
    input wire logic zero_set,
    // sensor steps, same clock
    input wire logic step_valid,
    input wire logic step_cw,
    // status
    output logic pos_valid,
    output logic [ssi_enc_pkg::POS_W-1:0] position
);
    localparam logic [ssi_enc_pkg::MONO_W-1:0] MONO_LOAD = ssi_enc_pkg::MONO_W'(MONO_CYC); // R10
    localparam logic [ssi_enc_pkg::AVAIL_W-1:0] AVAIL_LAST =
        ssi_enc_pkg::AVAIL_W'(AVAIL_CYC - 1);

    logic rst_n;
    logic sclk_s;
    logic dir_s;
    logic zs_s;

    // reset release and pin synchronisers
    sync2 #(.RST_VAL(1'b0)) u_rst (
        .clk(ref_clk),
        .rst_n(rstn),
        .d(1'b1),
        .q(rst_n)
    );
    sync2 #(.RST_VAL(1'b1)) u_sclk (
        .clk(ref_clk),
        .rst_n(rst_n),
        .d(ssi_clk),
        .q(sclk_s)
    );
    sync2 #(.RST_VAL(1'b0)) u_dir (
        .clk(ref_clk),
        .rst_n(rst_n),
        .d(dir_sel),
        .q(dir_s)
    );
    sync2 #(.RST_VAL(1'b1)) u_zs (
        .clk(ref_clk),
        .rst_n(rst_n),
        .d(zero_set),
        .q(zs_s)
    );

    // edge detection
    logic sclk_d_r;
    logic zs_d_r;
    logic sclk_fall;
    logic sclk_rise;
    logic zs_fall;

    assign sclk_fall = sclk_d_r & ~sclk_s;
    assign sclk_rise = ~sclk_d_r & sclk_s;
    assign zs_fall = zs_d_r & ~zs_s;

    // position and availability state
    logic [ssi_enc_pkg::POS_W-1:0] pos_r;
    logic [ssi_enc_pkg::POS_W-1:0] pos_nxt;
    logic [ssi_enc_pkg::POS_W-1:0] coded;
    logic [ssi_enc_pkg::AVAIL_W-1:0] avail_cnt_r;
    logic [ssi_enc_pkg::AVAIL_W-1:0] avail_cnt_nxt;
    logic avail_r;
    logic avail_nxt;
    logic up;

    always_comb begin
        up = step_cw ^ dir_s; // R3
        pos_nxt = pos_r;
        if (zs_fall) begin
            pos_nxt = ssi_enc_pkg::POS_RST; // R4
        end else if (step_valid) begin
            pos_nxt = up ? pos_r + 1'b1 : pos_r - 1'b1; // R1 R3
        end
        coded = GRAY_OUT ? (pos_r ^ (pos_r >> 1)) : pos_r; // R2 R10
        avail_cnt_nxt = avail_cnt_r;
        avail_nxt = avail_r;
        if (!avail_r) begin
            if (avail_cnt_r == AVAIL_LAST) begin
                avail_nxt = 1'b1; // R5
            end else begin
                avail_cnt_nxt = avail_cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_r <= ssi_enc_pkg::POS_RST;
            avail_cnt_r <= ssi_enc_pkg::AVAIL_RST;
            avail_r <= 1'b0;
            sclk_d_r <= ssi_enc_pkg::LINE_IDLE;
            zs_d_r <= 1'b1;
        end else begin
            pos_r <= pos_nxt;
            avail_cnt_r <= avail_cnt_nxt;
            avail_r <= avail_nxt;
            sclk_d_r <= sclk_s;
            zs_d_r <= zs_s;
        end
    end

    assign position = pos_r;
    assign pos_valid = avail_r;

    // transfer state
    ssi_enc_pkg::ssi_state_t state_r;
    ssi_enc_pkg::ssi_state_t state_nxt;
    logic [ssi_enc_pkg::POS_W-1:0] shreg_r;
    logic [ssi_enc_pkg::POS_W-1:0] shreg_nxt;
    logic [ssi_enc_pkg::CNT_W-1:0] bit_r;
    logic [ssi_enc_pkg::CNT_W-1:0] bit_nxt;
    logic [ssi_enc_pkg::MONO_W-1:0] mono_r;
    logic [ssi_enc_pkg::MONO_W-1:0] mono_nxt;
    logic data_r;
    logic data_nxt;

    always_comb begin
        state_nxt = state_r;
        shreg_nxt = shreg_r;
        bit_nxt = bit_r;
        mono_nxt = mono_r;
        data_nxt = data_r;
        case (state_r)
            ssi_enc_pkg::ST_IDLE: begin
                data_nxt = ssi_enc_pkg::LINE_IDLE; // R6
                if (sclk_fall && avail_r) begin
                    shreg_nxt = coded; // R7
                    bit_nxt = ssi_enc_pkg::CNT_RST;
                    mono_nxt = MONO_LOAD;
                    state_nxt = ssi_enc_pkg::ST_SHIFT;
                end
            end
            ssi_enc_pkg::ST_SHIFT: begin
                if (sclk_rise && bit_r != ssi_enc_pkg::LAST_BIT) begin
                    data_nxt = shreg_r[ssi_enc_pkg::POS_W-1]; // R8
                    shreg_nxt = {shreg_r[ssi_enc_pkg::POS_W-2:0], 1'b0}; // R8
                    bit_nxt = bit_r + 1'b1;
                    mono_nxt = MONO_LOAD;
                end else if (sclk_fall && bit_r == ssi_enc_pkg::LAST_BIT) begin
                    data_nxt = ssi_enc_pkg::LINE_MONO; // R9
                    mono_nxt = MONO_LOAD; // R9
                    state_nxt = ssi_enc_pkg::ST_MONO;
                end else if (sclk_rise || sclk_fall) begin
                    mono_nxt = MONO_LOAD;
                end else if (mono_r == ssi_enc_pkg::MONO_RST) begin
                    data_nxt = ssi_enc_pkg::LINE_IDLE;
                    state_nxt = ssi_enc_pkg::ST_IDLE;
                end else begin
                    mono_nxt = mono_r - 1'b1;
                end
            end
            ssi_enc_pkg::ST_MONO: begin
                data_nxt = ssi_enc_pkg::LINE_MONO;
                if (mono_r == ssi_enc_pkg::MONO_RST) begin
                    data_nxt = ssi_enc_pkg::LINE_IDLE; // R9
                    state_nxt = ssi_enc_pkg::ST_IDLE;
                end else begin
                    mono_nxt = mono_r - 1'b1;
                end
            end
            default: begin
                data_nxt = ssi_enc_pkg::LINE_IDLE;
                state_nxt = ssi_enc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ssi_enc_pkg::ST_IDLE;
            shreg_r <= ssi_enc_pkg::POS_RST;
            bit_r <= ssi_enc_pkg::CNT_RST;
            mono_r <= ssi_enc_pkg::MONO_RST;
            data_r <= ssi_enc_pkg::LINE_IDLE;
        end else begin
            state_r <= state_nxt;
            shreg_r <= shreg_nxt;
            bit_r <= bit_nxt;
            mono_r <= mono_nxt;
            data_r <= data_nxt;
        end
    end

    assign ssi_data = data_r;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    AST_IDLE_HIGH: assert property ( // R6
        state_r == ssi_enc_pkg::ST_IDLE && $past(state_r) == ssi_enc_pkg::ST_IDLE |-> ssi_data)
        else $error("data not high while idle");
    AST_NOT_AVAIL: assert property ( // R5
        !avail_r |-> ssi_data && state_r == ssi_enc_pkg::ST_IDLE)
        else $error("transfer before availability");
    AST_CAPTURE: assert property ( // R7
        state_r == ssi_enc_pkg::ST_IDLE && sclk_fall && avail_r
        |=> shreg_r == $past(coded) && state_r == ssi_enc_pkg::ST_SHIFT)
        else $error("position not captured on first falling edge");
    AST_MSB_FIRST: assert property ( // R8
        state_r == ssi_enc_pkg::ST_SHIFT && sclk_rise && bit_r == ssi_enc_pkg::CNT_RST
        |=> ssi_data == $past(shreg_r[ssi_enc_pkg::POS_W-1]))
        else $error("msb not driven on first rising edge");
    AST_ZERO_SET: assert property ( // R4
        zs_fall |=> pos_r == ssi_enc_pkg::POS_RST)
        else $error("zero-set edge did not clear position");
    AST_COUNT_UP: assert property ( // R3
        !zs_fall && step_valid && step_cw && !dir_s |=> pos_r == $past(pos_r) + 1'b1)
        else $error("clockwise step did not count up");
    AST_COUNT_DOWN: assert property ( // R3
        !zs_fall && step_valid && step_cw && dir_s |=> pos_r == $past(pos_r) - 1'b1)
        else $error("clockwise step did not count down");
    AST_MONO_LOW: assert property ( // R9
        state_r == ssi_enc_pkg::ST_SHIFT && sclk_fall && bit_r == ssi_enc_pkg::LAST_BIT
        |=> !ssi_data [*8])
        else $error("data not low after last bit");
    AST_MONO_END: assert property ( // R9
        state_r == ssi_enc_pkg::ST_MONO && mono_r == ssi_enc_pkg::MONO_RST
        |=> ssi_data && state_r == ssi_enc_pkg::ST_IDLE)
        else $error("data not released after monoflop");
    AST_CODING: assert property ( // R2
        state_r == ssi_enc_pkg::ST_IDLE && sclk_fall && avail_r
        |=> GRAY_OUT ? shreg_r == ($past(pos_r) ^ ($past(pos_r) >> 1)) : shreg_r == $past(pos_r))
        else $error("captured word has wrong coding");

    COV_TRANSFER: cover property (state_r == ssi_enc_pkg::ST_SHIFT ##1 state_r == ssi_enc_pkg::ST_MONO);
    COV_ABORT: cover property (state_r == ssi_enc_pkg::ST_SHIFT ##1 state_r == ssi_enc_pkg::ST_IDLE);
    COV_ZERO: cover property (zs_fall);
    COV_AVAIL: cover property ($rose(avail_r));
endmodule : ssi_encoder

// file: verif/ssi_master.sv
`timescale 1ns/1ps
module ssi_master #(
    parameter int N = 25
) (
    // bench side
    input wire logic ref_clk,
    input wire logic start,
    input wire logic [5:0] n_fall,
    output logic busy,
    output logic [N-1:0] word_a,
    output logic [N-1:0] word_b,
    output int low_cyc,
    // link side
    output logic ssi_clk,
    input wire logic data_a,
    input wire logic data_b
);
    initial begin
        ssi_clk = 1'b1;
        busy = 1'b0;
    end
    // burst of n_fall falls, bit sampled 30 ns after each later fall
    always @(posedge start) begin
        busy = 1'b1;
        low_cyc = 0;
        #7;
        for (int i = 0; i < n_fall; i++) begin
            ssi_clk = 1'b0;
            #30;
            if (i > 0) begin
                word_a = {word_a[N-2:0], data_a};
                word_b = {word_b[N-2:0], data_b};
            end
            #50;
            ssi_clk = 1'b1;
            if (i < n_fall - 1) #80;
        end
        // no new burst until data is high again
        for (int k = 0; k < 100 && !(data_a && low_cyc > 0); k++) begin
            @(negedge ref_clk);
            if (!data_a) low_cyc++;
        end
        busy = 1'b0;
    end
endmodule : ssi_master

// file: verif/absolute_encoder_ssi_slave_bench.sv
`timescale 1ns/1ps
module absolute_encoder_ssi_slave_bench;
    localparam int MONO = 40;
    localparam int AVAIL = 400;
    localparam int W = ssi_enc_pkg::POS_W;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic start = 1'b0;
    logic [5:0] n_fall = 6'h1a;
    logic dir_sel = 1'b0;
    logic zero_set = 1'b1;
    logic step_valid = 1'b0;
    logic step_cw = 1'b0;
    logic ssi_clk, data_a, data_b, busy, pos_valid;
    logic [W-1:0] position, word_a, word_b, exp_pos;
    int low_cyc, err_count = 0, num_checks = 0, seed = 2, cyc = 0;

    ssi_encoder #(.GRAY_OUT(1'b1), .MONO_CYC(MONO), .AVAIL_CYC(AVAIL)) dut (
        .ref_clk(ref_clk), .rstn(rstn), .ssi_clk(ssi_clk), .ssi_data(data_a),
        .dir_sel(dir_sel), .zero_set(zero_set), .step_valid(step_valid),
        .step_cw(step_cw), .pos_valid(pos_valid), .position(position));
    ssi_encoder #(.GRAY_OUT(1'b0), .MONO_CYC(MONO), .AVAIL_CYC(AVAIL)) dut_b (
        .ref_clk(ref_clk), .rstn(rstn), .ssi_clk(ssi_clk), .ssi_data(data_b),
        .dir_sel(dir_sel), .zero_set(zero_set), .step_valid(step_valid),
        .step_cw(step_cw), .pos_valid(), .position());
    ssi_master #(.N(W)) master (
        .ref_clk(ref_clk), .start(start), .n_fall(n_fall), .busy(busy), .word_a(word_a),
        .word_b(word_b), .low_cyc(low_cyc), .ssi_clk(ssi_clk),
        .data_a(data_a), .data_b(data_b));

    initial forever #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    function automatic logic [W-1:0] gray(input logic [W-1:0] p);
        return p ^ (p >> 1);
    endfunction : gray

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic xfer(input logic [W-1:0] ea, input logic [W-1:0] eb, input bit mono);
        chk(W'(data_a), W'(1'b1));
        @(posedge ref_clk);
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        for (int k = 0; k < 2000 && busy; k++) @(negedge ref_clk);
        if (busy) begin
            err_count++;
            test_done();
        end
        chk(word_a, ea);
        chk(word_b, eb);
        if (mono) chk(W'(low_cyc >= MONO - 2 && low_cyc <= MONO + 2), W'(1'b1));
        else chk(W'(low_cyc), '0);
    endtask : xfer

    // burst cut after ten falls, link must time out back to idle
    task automatic cut();
        @(posedge ref_clk);
        n_fall <= 6'h0a;
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        for (int k = 0; k < 2000 && busy; k++) @(negedge ref_clk);
        if (busy) begin
            err_count++;
            test_done();
        end
        repeat (MONO + 8) @(negedge ref_clk);
        n_fall <= 6'h1a;
        chk(W'(data_a), W'(1'b1));
    endtask : cut

    task automatic steps(input int n, input bit rnd);
        logic v, c;
        for (int i = 0; i < n; i++) begin
            v = rnd ? 1'($random(seed)) : 1'b1;
            c = rnd ? 1'($random(seed)) : 1'b1;
            @(posedge ref_clk);
            step_valid <= v;
            step_cw <= c;
            if (v) exp_pos = exp_pos + (((c ^ dir_sel) == 1'b1) ? W'(1) : {W{1'b1}});
        end
        @(posedge ref_clk);
        step_valid <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk(position, exp_pos);
    endtask : steps

    task automatic zero();
        @(posedge ref_clk);
        zero_set <= 1'b0;
        repeat (5) @(posedge ref_clk);
        exp_pos = '0;
        chk(position, exp_pos);
        zero_set <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk(position, exp_pos);
    endtask : zero

    task automatic set_dir(input logic d);
        @(posedge ref_clk);
        dir_sel <= d;
        repeat (4) @(posedge ref_clk);
    endtask : set_dir

    initial begin
        exp_pos = '0;
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (16) @(posedge ref_clk);
        chk(position, '0);
        xfer({W{1'b1}}, {W{1'b1}}, 1'b0);
        while (cyc < AVAIL) @(posedge ref_clk);
        chk(W'(pos_valid), '0);
        while (cyc < AVAIL + 15) @(posedge ref_clk);
        chk(W'(pos_valid), W'(1'b1));
        steps(300, 1'b1);
        xfer(gray(exp_pos), exp_pos, 1'b1);
        set_dir(1'b1);
        steps(300, 1'b1);
        xfer(gray(exp_pos), exp_pos, 1'b1);
        zero();
        steps(1, 1'b0);
        cut();
        xfer(gray(exp_pos), exp_pos, 1'b1);
        set_dir(1'b0);
        zero();
        steps(8193, 1'b0);
        xfer(gray(exp_pos), exp_pos, 1'b1);
        test_done();
    end
endmodule : absolute_encoder_ssi_slave_bench
